// ===== src/css_consts.svh
`ifndef CSS_CONSTS_SVH
`define CSS_CONSTS_SVH

// Register byte offsets on the bus
`define CSS_OFF_CTRL 8'h00
`define CSS_OFF_CFG 8'h04
`define CSS_OFF_ESS 8'h08
`define CSS_OFF_SCHED_ADDR 8'h0C
`define CSS_OFF_POP_RESULT 8'h10
`define CSS_OFF_OPERAND 8'h14
`define CSS_OFF_SVC_PTR 8'h18
`define CSS_OFF_SLOT_INDEX 8'h1C

// Control register fields
`define CSS_CTRL_POP_BIT 0
`define CSS_CTRL_PUSH_BIT 1
`define CSS_CTRL_TIMER_BIT 2

// State signal and configuration bits
`define CSS_ESS_ASSIGNED_BIT 4
`define CSS_ESS_BUSY_BIT 5
`define CSS_CFG_ERR_BIT 15

// Table geometry and service pointer step
`define CSS_SLOTS 4096
`define CSS_SLOT_W 12
`define CSS_PTR_STEP 16'h0002

// Pop completes this many cycles after issue
`define CSS_POP_CYCLES 4'h8

// Timer pacing default reload; ticks fall this many cycles plus one apart
`define CSS_TIMER_DEFAULT 16'h0100

// AXI responses
`define CSS_RESP_OKAY 2'b00
`define CSS_RESP_SLVERR 2'b10

`endif

// ===== src/css_pkg.sv
package css_pkg;

    // Scheduler operation state
    typedef enum logic [2:0] {
        CSS_IDLE,
        CSS_POP,
        CSS_SEARCH,
        CSS_DONE
    } css_state_t;

    // Register-visible state
    typedef struct packed {
        logic [15:0] operand;
        logic [15:0] svc_ptr;
        logic timer_mode;
        logic [15:0] timer_reload;
        logic [15:0] pop_result;
        logic [15:0] sched_addr;
        logic assigned;
        logic err;
    } css_regs_t;

    // Bus slave state
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
    } css_bus_t;

    // Whole block state
    typedef struct packed {
        css_bus_t bus;
        css_regs_t regs;
        css_state_t state;
        logic [3:0] cnt;
        logic [11:0] pos;
        logic [12:0] scanned;
        logic [15:0] timer_cnt;
        logic tick;
        logic pop_ready;
        // Operation running, registered copy for the state signal
        logic busy;
    } css_st_t;

endpackage

// ===== src/css_scheduler.sv
// Functional notes
// - Pop returns table entry at service pointer
// - Pop copies slot bit, then clears it
// - Busy flag bit 5 during operation; every read waits out a pop, so bit 5 reads back set only during a push
// - Assigned flag bit 4 shows popped bit
// - Push search starts at target slot
// - Take first free slot, store ID
// - Reserved slot address to result register
// - Back pressure: firmware fills idle cells
// - Free pop means firmware queues unassigned cell
// - Timer pacing marks transmission opportunities
// - Firmware pops only when queue not full
// - Firmware loads sixteen descriptor halfwords
// - Table addressed in halfwords
// - Service pointer advances two, modulo table; code wraps it in twelve bits, at half the table
// - Constant-rate reschedules at current slot
// - Dynamic connections hold one slot
// - Firmware carries fractional interval remainder
// - Search wraps from last to first
// - Operations never stall; result read waits
// - Full scoreboard sets config bit 15
// - Pop result eight cycles after issue
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "css_consts.svh"

module css_scheduler
    import css_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Write address channel
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // Write data channel; strobes ignored, writes are whole words
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // Write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read address channel
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // Read data channel
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // State signals and pacing tick
    output logic assigned_slot_flag,
    output logic schedule_in_progress_flag,
    output logic tx_opportunity
);

    ////////////////////////////////////////////////////////////////////////
    // Storage

    // Scoreboard, one bit per slot, cleared by reset
    // The table is not reset; an entry is valid only once pushed
    logic [`CSS_SLOTS-1:0] score_reg;
    // Connection identifier table
    logic [15:0] conn_table [`CSS_SLOTS];
    // Registered state and its next value
    css_st_t st_reg;
    css_st_t st_next;
    // Memory write request, decided in the comb process
    logic tbl_we;
    logic [11:0] tbl_waddr;
    logic [15:0] tbl_wdata;
    // Scoreboard bit request, one address for set and clear
    logic sb_set;
    logic sb_clr;
    logic [11:0] sb_addr;
    // Table read data, registered
    logic [15:0] tbl_rdata_reg;

    // Halfword address to slot index
    // Bit 0 picks a halfword within the slot and is dropped: only whole slots are scheduled
    function automatic logic [11:0] slot_of(input logic [15:0] hw_addr);
        slot_of = hw_addr[12:1];
    endfunction

    // Slot index back to halfword address
    // Result is always even, with the top bits zero
    function automatic logic [15:0] addr_of(input logic [11:0] slot);
        addr_of = {3'h0, slot, 1'b0};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic

    // Bus slave, operation sequencer and pacing timer
    always_comb begin
        // Low half of the write data and the read address
        logic [15:0] wv;
        logic [7:0] ra;
        wv = 16'h0000;
        ra = 8'h00;
        // By default hold every field and request no memory access
        st_next = st_reg;
        tbl_we = 1'b0;
        tbl_waddr = 12'h000;
        tbl_wdata = 16'h0000;
        sb_set = 1'b0;
        sb_clr = 1'b0;
        sb_addr = st_reg.pos;

        // Write address and data, taken in either order
        if (s_axi_awvalid && st_reg.bus.awready) begin
            st_next.bus.aw_got = 1'b1;
            st_next.bus.aw_addr = s_axi_awaddr;
            st_next.bus.awready = 1'b0;
        end
        if (s_axi_wvalid && st_reg.bus.wready) begin
            st_next.bus.w_got = 1'b1;
            st_next.bus.w_data = s_axi_wdata;
            st_next.bus.wready = 1'b0;
        end
        // Response once both halves have arrived
        if (st_reg.bus.aw_got && st_reg.bus.w_got && !st_reg.bus.bvalid) begin
            wv = st_reg.bus.w_data[15:0];
            st_next.bus.aw_got = 1'b0;
            st_next.bus.w_got = 1'b0;
            st_next.bus.bvalid = 1'b1;
            st_next.bus.bresp = `CSS_RESP_OKAY;
            case (st_reg.bus.aw_addr)
                `CSS_OFF_CTRL: begin
                    // Busy ignores new commands; operations do not queue
                    if (st_reg.state == CSS_IDLE) begin
                        // Pop wins when both command bits are set
                        // Whether to pop at all is firmware's call
                        if (wv[`CSS_CTRL_POP_BIT]) begin
                            st_next.state = CSS_POP;
                            st_next.cnt = 4'h1;
                            st_next.pos = slot_of(st_reg.regs.svc_ptr);
                            st_next.pop_ready = 1'b0;
                        end else if (wv[`CSS_CTRL_PUSH_BIT]) begin
                            // Exact target, so rescheduling keeps a slot
                            st_next.state = CSS_SEARCH;
                            st_next.pos = slot_of(st_reg.regs.operand);
                            st_next.scanned = 13'h0000;
                        end
                    end
                    st_next.regs.timer_mode = wv[`CSS_CTRL_TIMER_BIT];
                end
                `CSS_OFF_CFG: begin
                    // Error flag cleared by writing zero to it
                    st_next.regs.err = wv[`CSS_CFG_ERR_BIT] & st_reg.regs.err;
                    st_next.regs.timer_reload = st_reg.bus.w_data[31:16];
                end
                // Operand is both push target and connection identifier
                `CSS_OFF_OPERAND: st_next.regs.operand = wv;
                // Service pointer, a halfword address
                `CSS_OFF_SVC_PTR: st_next.regs.svc_ptr = wv;
                `CSS_OFF_SLOT_INDEX: begin
                    // Advance pointer by two, wrapping in twelve bits
                    st_next.regs.svc_ptr = {4'h0, 12'(
                        st_reg.regs.svc_ptr[11:0] + `CSS_PTR_STEP)};
                end
                // Unmapped offsets are refused
                default: st_next.bus.bresp = `CSS_RESP_SLVERR;
            endcase
        end
        // Response taken: open both channels for the next write
        if (st_reg.bus.bvalid && s_axi_bready) begin
            st_next.bus.bvalid = 1'b0;
            st_next.bus.awready = 1'b1;
            st_next.bus.wready = 1'b1;
        end

        // Read channel; pop result read waits for the pop
        ra = s_axi_araddr;
        // Ready is low while a pop runs, so a result read is held off
        // until the result stands; no handshake is ever dropped
        if (s_axi_arvalid && st_reg.bus.arready) begin
            st_next.bus.arready = 1'b0;
            st_next.bus.rvalid = 1'b1;
            st_next.bus.rresp = `CSS_RESP_OKAY;
            st_next.bus.rdata = 32'h0000_0000;
            case (ra)
                // Only the timer mode bit reads back
                `CSS_OFF_CTRL:
                    st_next.bus.rdata[`CSS_CTRL_TIMER_BIT] =
                        st_reg.regs.timer_mode;
                // Error flag and timer reload
                `CSS_OFF_CFG: begin
                    st_next.bus.rdata[`CSS_CFG_ERR_BIT] = st_reg.regs.err;
                    st_next.bus.rdata[31:16] = st_reg.regs.timer_reload;
                end
                // Assigned and busy flags
                `CSS_OFF_ESS: begin
                    st_next.bus.rdata[`CSS_ESS_ASSIGNED_BIT] =
                        st_reg.regs.assigned;
                    st_next.bus.rdata[`CSS_ESS_BUSY_BIT] =
                        (st_reg.state != CSS_IDLE);
                end
                // Halfword address of the last slot reserved
                `CSS_OFF_SCHED_ADDR:
                    st_next.bus.rdata[15:0] = st_reg.regs.sched_addr;
                // Identifier from the last pop
                `CSS_OFF_POP_RESULT:
                    st_next.bus.rdata[15:0] = st_reg.regs.pop_result;
                `CSS_OFF_OPERAND:
                    st_next.bus.rdata[15:0] = st_reg.regs.operand;
                `CSS_OFF_SVC_PTR:
                    st_next.bus.rdata[15:0] = st_reg.regs.svc_ptr;
                // Step register reads back the pointer
                `CSS_OFF_SLOT_INDEX:
                    st_next.bus.rdata[15:0] = st_reg.regs.svc_ptr;
                // Unmapped offsets are refused
                default: st_next.bus.rresp = `CSS_RESP_SLVERR;
            endcase
        end
        // Data taken: the read channel is free again
        if (st_reg.bus.rvalid && s_axi_rready) begin
            st_next.bus.rvalid = 1'b0;
            st_next.bus.arready = 1'b1;
        end

        // Operation sequencer
        case (st_reg.state)
            CSS_IDLE: begin
                // Waits for a command from the control register
            end
            CSS_POP: begin
                // Table data lag the slot index by one cycle
                st_next.cnt = st_reg.cnt + 4'h1;
                if (st_reg.cnt == 4'h1) begin
                    // Sample bit, then clear it
                    st_next.regs.assigned = score_reg[st_reg.pos];
                    sb_clr = 1'b1;
                    if (&score_reg)
                        st_next.regs.err = 1'b1;
                end
                if (st_reg.cnt == `CSS_POP_CYCLES - 4'h1) begin
                    st_next.regs.pop_result = tbl_rdata_reg;
                    st_next.pop_ready = 1'b1;
                    st_next.state = CSS_IDLE;
                end
            end
            CSS_SEARCH: begin
                if (st_reg.scanned == 13'(`CSS_SLOTS)) begin
                    // Whole scoreboard busy
                    st_next.regs.err = 1'b1;
                    st_next.state = CSS_IDLE;
                end else if (!score_reg[st_reg.pos]) begin
                    // Free slot: each push reserves exactly one bit
                    sb_set = 1'b1;
                    tbl_we = 1'b1;
                    tbl_waddr = st_reg.pos;
                    tbl_wdata = st_reg.regs.operand;
                    st_next.state = CSS_DONE;
                end else begin
                    // Slot taken; index wraps past the last bit
                    st_next.pos = st_reg.pos + 12'h001;
                    st_next.scanned = st_reg.scanned + 13'h0001;
                end
            end
            CSS_DONE: begin
                // Report the slot actually reserved
                st_next.regs.sched_addr = addr_of(st_reg.pos);
                st_next.state = CSS_IDLE;
            end
            default: st_next.state = CSS_IDLE;
        endcase

        // Pacing timer for timer mode
        st_next.tick = 1'b0;
        if (st_reg.regs.timer_mode) begin
            if (st_reg.timer_cnt == 16'h0000) begin
                st_next.timer_cnt = st_reg.regs.timer_reload;
                st_next.tick = 1'b1;
            end else begin
                st_next.timer_cnt = st_reg.timer_cnt - 16'h0001;
            end
        end else begin
            // Back pressure pacing: no tick, firmware keeps the stream full
            st_next.timer_cnt = st_reg.regs.timer_reload;
        end

        // Registered copies feeding the flag output and read ready
        st_next.busy = (st_next.state != CSS_IDLE);
        st_next.bus.arready = !st_next.bus.rvalid &&
            st_next.pop_ready;
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers

    // Whole state, reset to idle with flags at zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= '0;
            st_reg.bus.awready <= 1'b1;
            st_reg.bus.wready <= 1'b1;
            st_reg.bus.arready <= 1'b1;
            st_reg.regs.timer_reload <= `CSS_TIMER_DEFAULT;
            st_reg.timer_cnt <= `CSS_TIMER_DEFAULT;
            st_reg.state <= CSS_IDLE;
            // No pop pending, so the read channel starts open
            st_reg.pop_ready <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // Scoreboard bit updates
    // A push sets and a pop clears; they never fall in one cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            score_reg <= '0;
        end else if (sb_set) begin
            score_reg[sb_addr] <= 1'b1;
        end else if (sb_clr) begin
            score_reg[sb_addr] <= 1'b0;
        end
    end

    // Connection table, synchronous read and write
    // Read address follows the slot index held in state
    always_ff @(posedge clk) begin
        if (tbl_we) begin
            conn_table[tbl_waddr] <= tbl_wdata;
        end
        tbl_rdata_reg <= conn_table[st_reg.pos];
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, straight from flip-flops

    assign s_axi_awready = st_reg.bus.awready;
    assign s_axi_wready = st_reg.bus.wready;
    assign s_axi_bvalid = st_reg.bus.bvalid;
    assign s_axi_bresp = st_reg.bus.bresp;
    assign s_axi_arready = st_reg.bus.arready;
    assign s_axi_rvalid = st_reg.bus.rvalid;
    assign s_axi_rdata = st_reg.bus.rdata;
    assign s_axi_rresp = st_reg.bus.rresp;
    assign assigned_slot_flag = st_reg.regs.assigned;
    assign schedule_in_progress_flag = st_reg.busy;
    assign tx_opportunity = st_reg.tick;

endmodule

// ===== verif/css_scheduler_props.sv
`timescale 1ns/1ps
// Port-level checks on the scheduler
module css_scheduler_props (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic assigned_slot_flag,
    input wire logic schedule_in_progress_flag,
    input wire logic tx_opportunity
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Both write channels taken at one edge
    sequence s_write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    a_flags_after_reset: assert property (
        $rose(reset_n) |-> !assigned_slot_flag && !schedule_in_progress_flag)
        else $error("flags not clear after reset");
    a_op_sets_busy: assert property (
        s_write_taken ##0 (s_axi_awaddr == 8'h00 && s_axi_wdata[1:0] != 2'b00
        && !schedule_in_progress_flag) |-> ##[1:3] schedule_in_progress_flag)
        else $error("command did not raise busy");
    a_assigned_quiet: assert property (
        !schedule_in_progress_flag && !$past(schedule_in_progress_flag)
        |-> $stable(assigned_slot_flag))
        else $error("assigned flag moved while idle");
    a_tick_single: assert property (
        tx_opportunity |=> !tx_opportunity [*8])
        else $error("pacing tick too long or too close");
    a_awready_drop: assert property (
        s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("awready stayed up after take");
    a_bvalid_once: assert property (
        s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid ##[0:1] (s_axi_awready && s_axi_wready))
        else $error("write response not retired");
    a_rvalid_once: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response repeated");
    a_read_okay: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr < 8'h20
        |=> s_axi_rvalid && s_axi_rresp == 2'b00)
        else $error("mapped read not answered okay");
    a_read_slverr: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h20
        |=> s_axi_rvalid && s_axi_rresp == 2'b10)
        else $error("unmapped read not refused");
    a_write_slverr: assert property (
        s_write_taken ##0 s_axi_awaddr >= 8'h20
        |-> ##[1:2] (s_axi_bvalid && s_axi_bresp == 2'b10))
        else $error("unmapped write not refused");
    // Pop command taken while idle
    sequence s_pop_cmd;
        s_write_taken ##0 (s_axi_awaddr == 8'h00 && s_axi_wdata[0]
        && !schedule_in_progress_flag);
    endsequence
    a_pop_latency: assert property (
        s_pop_cmd |-> ##2 schedule_in_progress_flag [*7]
        ##1 !schedule_in_progress_flag)
        else $error("pop did not finish in eight cycles");
endmodule

// ===== verif/css_host_model.sv
`timescale 1ns/1ps
// Processor side of the register bus, one access at a time
module css_host_model (
    input wire logic clk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    // Bus idle at time zero
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end
    // Address and data offered together, each dropped once taken
    task automatic wr_word(input logic [7:0] a, input logic [31:0] d,
        output logic [1:0] resp);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    // Waits out a stalled result read as long as it takes
    task automatic rd_word(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] resp);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule

// ===== verif/css_scheduler_tb.sv
`timescale 1ns/1ps
`include "css_consts.svh"
// Self-checking bench for the cell slot scheduler
module css_scheduler_tb;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, tx_opportunity;
    logic assigned_slot_flag, schedule_in_progress_flag;
    logic [31:0] ticks = 32'h0;
    int n_errors = 0;
    int num_checks = 0;
    css_scheduler css_scheduler_i (.*);
    css_host_model css_host_model_i (.*);
    always #4 clk = ~clk;
    // Count pacing pulses
    always @(posedge clk) if (tx_opportunity === 1'b1) ticks <= ticks + 32'h1;
    ////////////////////////////////////////
    // Compare and count
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Write one register, expecting an okay response
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        css_host_model_i.wr_word(a, d, r);
        check("bresp", {30'h0, r}, {30'h0, `CSS_RESP_OKAY});
    endtask
    // Read one register and compare it
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        css_host_model_i.rd_word(a, d, r);
        check("rresp", {30'h0, r}, {30'h0, `CSS_RESP_OKAY});
        check("rdata", d, exp);
    endtask
    // Poll until no operation runs
    task automatic wait_idle();
        logic [31:0] d;
        logic [1:0] r;
        do css_host_model_i.rd_word(`CSS_OFF_ESS, d, r);
        while (d[5] !== 1'b0);
    endtask
    // Reserve a slot from operand target and identifier
    task automatic push(input logic [15:0] op);
        wr(`CSS_OFF_OPERAND, {16'h0, op});
        wr(`CSS_OFF_CTRL, 32'h2);
        wait_idle();
    endtask
    // Service one slot, compare identifier and state signals
    task automatic pop(input logic [15:0] p, input logic [31:0] id,
        input logic [31:0] external_state_signals);
        wr(`CSS_OFF_SVC_PTR, {16'h0, p});
        wr(`CSS_OFF_CTRL, 32'h1);
        rd_chk(`CSS_OFF_POP_RESULT, id);
        rd_chk(`CSS_OFF_ESS, external_state_signals);
    endtask
    // Verdict and end of run
    task automatic results();
        if (n_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    // Main sequence
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rd_chk(`CSS_OFF_ESS, 32'h0);
        rd_chk(`CSS_OFF_CFG, 32'h01000000);
        wr(`CSS_OFF_CTRL, 32'h4);
        repeat (600) @(posedge clk);
        check("ticks on", ticks, 32'h2);
        wr(`CSS_OFF_CTRL, 32'h0);
        repeat (600) @(posedge clk);
        check("ticks off", ticks, 32'h2);
        // Slot 10 taken, second push collides into slot 11
        push(16'h0014);
        rd_chk(`CSS_OFF_SCHED_ADDR, 32'h14);
        push(16'h0015);
        rd_chk(`CSS_OFF_SCHED_ADDR, 32'h16);
        pop(16'h0016, 32'h15, 32'h10);
        pop(16'h0014, 32'h14, 32'h10);
        pop(16'h0016, 32'h15, 32'h0);
        // Search runs off the last slot to the first
        push(16'h1FFE);
        rd_chk(`CSS_OFF_SCHED_ADDR, 32'h1FFE);
        push(16'h1FFF);
        rd_chk(`CSS_OFF_SCHED_ADDR, 32'h0);
        wr(`CSS_OFF_SVC_PTR, 32'hFFE);
        wr(`CSS_OFF_SLOT_INDEX, 32'h0);
        rd_chk(`CSS_OFF_SVC_PTR, 32'h0);
        // Unmapped places are refused
        css_host_model_i.rd_word(8'h20, d, r);
        check("rresp", {30'h0, r}, {30'h0, `CSS_RESP_SLVERR});
        css_host_model_i.wr_word(8'h24, 32'h1, r);
        check("bresp", {30'h0, r}, {30'h0, `CSS_RESP_SLVERR});
        // Fill all slots, then one more push finds none
        for (int i = 0; i < 4094; i++) push(16'(i * 2));
        wr(`CSS_OFF_OPERAND, 32'h0);
        wr(`CSS_OFF_CTRL, 32'h2);
        rd_chk(`CSS_OFF_ESS, 32'h20);
        wait_idle();
        rd_chk(`CSS_OFF_CFG, 32'h01008000);
        wr(`CSS_OFF_CFG, 32'h01000000);
        rd_chk(`CSS_OFF_CFG, 32'h01000000);
        results();
    end
    // Cut a hang short
    initial begin
        repeat (98000) @(posedge clk);
        n_errors++;
        results();
    end
endmodule
bind css_scheduler css_scheduler_props css_scheduler_props_i (.*);
